//--- verilog/cbsel_pkg.sv
`default_nettype none
// ==========================================================
// shared constants for the curve buffer selection block
package cbsel_pkg;

  // register byte offsets
  localparam logic [4:0] CBSEL_OFF_CTRL   = 5'h00;
  localparam logic [4:0] CBSEL_OFF_SELECT = 5'h04;
  localparam logic [4:0] CBSEL_OFF_LENGTH = 5'h08;
  localparam logic [4:0] CBSEL_OFF_STATUS = 5'h0c;
  localparam logic [4:0] CBSEL_OFF_CMD    = 5'h10;
  localparam logic [4:0] CBSEL_OFF_MAXLEN = 5'h14;
  localparam logic [4:0] CBSEL_OFF_SWEEPS = 5'h18;
  localparam logic [4:0] CBSEL_OFF_POINTS = 5'h1c;

  // field positions
  localparam int CBSEL_CTRL_MODE_BIT   = 0;  // buffer_mode_select
  localparam int CBSEL_CTRL_DUAL_BIT   = 1;  // dual reference mode
  localparam int CBSEL_STAT_PERR_BIT   = 0;  // sticky parameter error
  localparam int CBSEL_STAT_DUMP_BIT   = 1;  // last dump check result
  localparam int CBSEL_CMD_SELQ_BIT    = 0;  // selection query, no parameter
  localparam int CBSEL_CMD_LENQ_BIT    = 1;  // length query, no parameter
  localparam int CBSEL_CMD_NEWC_BIT    = 2;  // new curve

  // selection word layout
  localparam int CBSEL_SEL_W       = 22;
  localparam int CBSEL_SINGLE_W    = 17;
  localparam int CBSEL_SENS_BIT    = 4;
  localparam int CBSEL_EVENT_BIT   = 14;
  localparam int CBSEL_FLO_BIT     = 15;
  localparam int CBSEL_FHI_BIT     = 16;
  localparam int CBSEL_SENS2_BIT   = 21;
  localparam logic [21:0] CBSEL_MEASURED_MASK = 22'h1e_3fef;
  localparam logic [21:0] CBSEL_SINGLE_MASK   = 22'h01_ffff;
  localparam logic [4:0]  CBSEL_LAST_SINGLE   = 5'h10;
  localparam logic [4:0]  CBSEL_LAST_DUAL     = 5'h15;

  // storage sizes
  localparam logic [16:0] CBSEL_TOTAL_POINTS = 17'h1_86a0;
  localparam logic [16:0] CBSEL_FAST_MIN_LEN = 17'h0_012c;

  // input mode offsets added to the sensitivity code
  localparam logic [15:0] CBSEL_INPUT_MODE_CODE_OFF0 = 16'h0000;
  localparam logic [15:0] CBSEL_INPUT_MODE_CODE_OFF1 = 16'h0020;
  localparam logic [15:0] CBSEL_INPUT_MODE_CODE_OFF2 = 16'h0040;
  localparam logic [15:0] CBSEL_INPUT_MODE_CODE_OFF3 = 16'h0080;

  // reset values
  localparam logic [21:0] CBSEL_SELECT_RST = 22'h00_0001;
  localparam logic [16:0] CBSEL_LENGTH_RST = 17'h1_86a0;

  typedef enum logic [1:0] {CBSEL_BUS_IDLE, CBSEL_BUS_ACK} cbsel_bus_t;
  typedef enum logic       {CBSEL_W_IDLE, CBSEL_W_WALK} cbsel_walk_t;

endpackage
`default_nettype wire

//--- verilog/cbsel_maxlen.sv
`timescale 1ns/1ns
`default_nettype none
// ==========================================================
// curve count and largest curve length for a selection
module cbsel_maxlen
  import cbsel_pkg::*;
(
  input  wire logic [21:0] select_word,
  input  wire logic        fast_mode,
  output logic      [4:0]  curve_count,
  output logic      [16:0] max_length
);

  // the frequency pair is two set bits, so it counts as two curves
  always_comb begin
    curve_count = 5'h00;
    for (int i = 0; i < CBSEL_SEL_W; i++) begin
      curve_count = curve_count + {4'h0, select_word[i]};
    end
  end

  // divider is combinational; the count settles long before any bus read
  always_comb begin
    if (fast_mode || curve_count == 5'h00) begin
      max_length = CBSEL_TOTAL_POINTS;
    end else begin
      max_length = CBSEL_TOTAL_POINTS / {12'h000, curve_count};
    end
  end

endmodule
`default_nettype wire

//--- verilog/cbsel_top.sv
// Function
// - mode 0 selects standard buffer, mode 1 selects fast buffer.
// - single reference selection is 17 bits, value 1 to 131071.
// - dual modes widen selection to 22 bits, value 1 to 4194303.
// - each set selection bit up to the mode's last bit (16 or 21) stores its output; clear bits store nothing.
// - bits 0-3 store X, Y, magnitude, phase at their scales.
// - bits 5-13 store noise, ratios, four aux inputs, two user outputs.
// - bits 4 and 21 store sensitivity plus input mode offset.
// - bit 14 stores the event marker, 0 to 32767.
// - bits 15 and 16 store low and high frequency halves.
// - setting either frequency bit sets the other automatically.
// - dual modes add bits 17-20 for second channel outputs.
// - standard mode shares 100000 points equally among curves.
// - the frequency pair counts as two curves.
// - in standard mode, curve length never exceeds 100000 divided by curve count; on leaving fast mode it stays over for one cycle before the cut.
// - a larger selection auto-reduces length to the largest fit.
// - length read returns the length actually in effect.
// - selection must hold a measured-output bit, else invalid.
// - the selection governs later acquisitions of every kind.
// - selection limits dumpable curves and monitor counts.
// - selection or length query clears sweep and point counts.
// - fast mode length writes are bounded 300 to 100000; a shorter length kept from standard mode stays.
`timescale 1ns/1ns
`default_nettype none
module cbsel_top
  import cbsel_pkg::*;
(
  input  wire logic        mclk,
  input  wire logic        reset_n,
  // avalon-mm slave
  input  wire logic [4:0]  address,
  input  wire logic        read,
  input  wire logic        write,
  input  wire logic [3:0]  byteenable,
  input  wire logic [31:0] writedata,
  output logic      [31:0] readdata,
  output logic             waitrequest,
  // acquisition side
  input  wire logic        acq_start,
  input  wire logic        sample_strobe,
  output logic             sample_ready,
  input  wire logic        point_taken,
  input  wire logic        sweep_done,
  // measured values
  input  wire logic [15:0] x_in,
  input  wire logic [15:0] y_in,
  input  wire logic [15:0] mag_in,
  input  wire logic [15:0] phase_in,
  input  wire logic [4:0]  sens_in,
  input  wire logic [1:0]  input_mode_code,
  input  wire logic [15:0] noise_in,
  input  wire logic [15:0] ratio_in,
  input  wire logic [15:0] log_ratio_in,
  input  wire logic [63:0] aux_in,
  input  wire logic [31:0] user_out_in,
  input  wire logic [14:0] event_in,
  input  wire logic [31:0] ref_freq_in,
  input  wire logic [63:0] ch2_in,
  input  wire logic [4:0]  sens2_in,
  input  wire logic [1:0]  input_mode_code2,
  // store stream
  output logic             store_valid,
  output logic      [4:0]  store_bit,
  output logic      [15:0] store_data,
  // dump request check
  input  wire logic [4:0]  dump_curve_num,
  output logic             dump_allowed,
  // configuration state
  output logic             buffer_mode_select,
  output logic      [21:0] curve_select_word,
  output logic      [16:0] curve_length
);

  // ==========================================================
  // helpers
  function automatic logic [15:0] input_mode_code_offset(input logic [1:0] m);
    unique case (m)
      2'd0: input_mode_code_offset = CBSEL_INPUT_MODE_CODE_OFF0;
      2'd1: input_mode_code_offset = CBSEL_INPUT_MODE_CODE_OFF1;
      2'd2: input_mode_code_offset = CBSEL_INPUT_MODE_CODE_OFF2;
      2'd3: input_mode_code_offset = CBSEL_INPUT_MODE_CODE_OFF3;
    endcase
  endfunction

  // merge written bytes over the old word
  function automatic logic [31:0] be_merge(input logic [31:0] old_v, input logic [31:0] new_v,
                                           input logic [3:0] be);
    for (int b = 0; b < 4; b++) begin
      be_merge[b*8 +: 8] = be[b] ? new_v[b*8 +: 8] : old_v[b*8 +: 8];
    end
  endfunction

  // ==========================================================
  // state
  cbsel_bus_t  bus_reg;
  cbsel_walk_t walk_reg;
  logic        dual_reg;
  logic        perr_reg;
  logic [21:0] select_reg;
  logic [21:0] active_sel_reg;
  logic [16:0] length_reg;
  logic [31:0] sweeps_reg;
  logic [31:0] points_reg;
  logic [4:0]  idx_reg;
  logic [4:0]  curve_count;
  logic [16:0] max_length;
  logic [4:0]  new_count;
  logic [16:0] new_max;
  logic        bus_fire;
  logic        wr_fire;
  logic        sel_wr;
  logic        len_wr;
  logic [21:0] sel_cand;
  logic        sel_ok;
  logic [16:0] len_cand;
  logic        len_ok;
  logic        cnt_clear;
  logic [15:0] slot_val;
  logic [4:0]  last_idx;
  logic [31:0] sel_merged;
  logic [31:0] len_merged;

  cbsel_maxlen u_cur (
    .select_word (select_reg),
    .fast_mode   (buffer_mode_select),
    .curve_count (curve_count),
    .max_length  (max_length)
  );

  // ==========================================================
  // bus slave: one wait cycle, then the request is taken
  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      bus_reg <= CBSEL_BUS_IDLE;
    end else if (bus_reg == CBSEL_BUS_ACK) begin
      bus_reg <= CBSEL_BUS_IDLE;
    end else if (read || write) begin
      bus_reg <= CBSEL_BUS_ACK;
    end
  end

  assign bus_fire    = (bus_reg == CBSEL_BUS_ACK) && (read || write);
  assign waitrequest = (read || write) && (bus_reg != CBSEL_BUS_ACK);
  assign wr_fire     = bus_fire && write;
  assign sel_wr      = wr_fire && address == CBSEL_OFF_SELECT;
  assign len_wr      = wr_fire && address == CBSEL_OFF_LENGTH;

  // read data latched while waitrequest is high, stands at the taking edge
  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      readdata <= 32'h0000_0000;
    end else if (read && bus_reg == CBSEL_BUS_IDLE) begin
      unique case (address)
        CBSEL_OFF_CTRL:   readdata <= {30'h0, dual_reg, buffer_mode_select};
        CBSEL_OFF_SELECT: readdata <= {10'h000, select_reg};
        CBSEL_OFF_LENGTH: readdata <= {15'h0000, length_reg};
        CBSEL_OFF_STATUS: readdata <= {19'h0_0000, curve_count, 6'h00, dump_allowed, perr_reg};
        CBSEL_OFF_MAXLEN: readdata <= {15'h0000, max_length};
        CBSEL_OFF_SWEEPS: readdata <= sweeps_reg;
        CBSEL_OFF_POINTS: readdata <= points_reg;
        default:          readdata <= 32'h0000_0000;
      endcase
    end
  end

  // ==========================================================
  // control register
  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      buffer_mode_select <= 1'b0;
      dual_reg           <= 1'b0;
    end else if (wr_fire && address == CBSEL_OFF_CTRL && byteenable[0]) begin
      buffer_mode_select <= writedata[CBSEL_CTRL_MODE_BIT];
      dual_reg           <= writedata[CBSEL_CTRL_DUAL_BIT];
    end
  end

  // ==========================================================
  // selection word check
  assign sel_merged = be_merge({10'h000, select_reg}, writedata, byteenable);

  always_comb begin
    sel_cand = sel_merged[21:0];
    if (sel_cand[CBSEL_FLO_BIT] || sel_cand[CBSEL_FHI_BIT]) begin
      sel_cand[CBSEL_FLO_BIT] = 1'b1;
      sel_cand[CBSEL_FHI_BIT] = 1'b1;
    end
    // upper bits beyond the mode's width are out of range
    sel_ok = (sel_merged[31:22] == 10'h000)
             && (dual_reg || (sel_cand & ~CBSEL_SINGLE_MASK) == 22'h00_0000)
             && (sel_cand & CBSEL_MEASURED_MASK) != 22'h00_0000;
  end

  cbsel_maxlen u_new (
    .select_word (sel_cand),
    .fast_mode   (buffer_mode_select),
    .curve_count (new_count),
    .max_length  (new_max)
  );

  // rejected word leaves the old selection in place
  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      select_reg <= CBSEL_SELECT_RST;
    end else if (sel_wr && sel_ok) begin
      select_reg <= sel_cand;
    end
  end

  // ==========================================================
  // curve length: checked on write, cut down when a selection grows
  assign len_merged = be_merge({15'h0000, length_reg}, writedata, byteenable);

  always_comb begin
    len_cand = len_merged[16:0];
    if (buffer_mode_select) begin
      len_ok = len_cand >= CBSEL_FAST_MIN_LEN && len_cand <= CBSEL_TOTAL_POINTS;
    end else begin
      len_ok = len_cand != 17'h0_0000 && len_cand <= max_length;
    end
    len_ok = len_ok && len_merged[31:17] == 15'h0000;
  end

  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      length_reg <= CBSEL_LENGTH_RST;
    end else if (len_wr && len_ok) begin
      length_reg <= len_cand;
    end else if (sel_wr && sel_ok && !buffer_mode_select && length_reg > new_max) begin
      length_reg <= new_max;
    end else if (!buffer_mode_select && length_reg > max_length) begin
      length_reg <= max_length;  // leaving fast mode may leave too long a curve
    end
  end

  // ==========================================================
  // sticky parameter error; a new error wins over the clear
  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      perr_reg <= 1'b0;
    end else if ((sel_wr && !sel_ok) || (len_wr && !len_ok)) begin
      perr_reg <= 1'b1;
    end else if (wr_fire && address == CBSEL_OFF_STATUS && byteenable[0]
                 && writedata[CBSEL_STAT_PERR_BIT]) begin
      perr_reg <= 1'b0;
    end
  end

  // ==========================================================
  // sweep and point counters for the status monitor
  assign cnt_clear = wr_fire && address == CBSEL_OFF_CMD && byteenable[0]
                     && (writedata[CBSEL_CMD_SELQ_BIT] || writedata[CBSEL_CMD_LENQ_BIT]
                         || writedata[CBSEL_CMD_NEWC_BIT]);

  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      sweeps_reg <= 32'h0000_0000;
      points_reg <= 32'h0000_0000;
    end else if (cnt_clear) begin
      sweeps_reg <= 32'h0000_0000;
      points_reg <= 32'h0000_0000;
    end else begin
      sweeps_reg <= sweeps_reg + {31'h0000_0000, sweep_done};
      points_reg <= points_reg + {31'h0000_0000, point_taken};
    end
  end

  // ==========================================================
  // selection frozen at acquisition start governs that acquisition
  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      active_sel_reg <= CBSEL_SELECT_RST;
    end else if (acq_start) begin
      active_sel_reg <= select_reg;
    end
  end

  assign curve_select_word = select_reg;
  assign curve_length      = length_reg;

  // dump check: curve must be stored and inside the current width
  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      dump_allowed <= 1'b0;
    end else begin
      dump_allowed <= dump_curve_num <= last_idx && select_reg[dump_curve_num];
    end
  end

  // ==========================================================
  // sample value for the walked selection bit
  always_comb begin
    unique case (idx_reg)
      5'd0:    slot_val = x_in;
      5'd1:    slot_val = y_in;
      5'd2:    slot_val = mag_in;
      5'd3:    slot_val = phase_in;
      5'd4:    slot_val = {11'h000, sens_in} + input_mode_code_offset(input_mode_code);
      5'd5:    slot_val = noise_in;
      5'd6:    slot_val = ratio_in;
      5'd7:    slot_val = log_ratio_in;
      5'd8:    slot_val = aux_in[15:0];
      5'd9:    slot_val = aux_in[31:16];
      5'd10:   slot_val = aux_in[47:32];
      5'd11:   slot_val = aux_in[63:48];
      5'd12:   slot_val = user_out_in[15:0];
      5'd13:   slot_val = user_out_in[31:16];
      5'd14:   slot_val = {1'b0, event_in};
      5'd15:   slot_val = ref_freq_in[15:0];
      5'd16:   slot_val = ref_freq_in[31:16];
      5'd17:   slot_val = ch2_in[15:0];
      5'd18:   slot_val = ch2_in[31:16];
      5'd19:   slot_val = ch2_in[47:32];
      5'd20:   slot_val = ch2_in[63:48];
      5'd21:   slot_val = {11'h000, sens2_in} + input_mode_code_offset(input_mode_code2);
      default: slot_val = 16'h0000;
    endcase
  end

  assign last_idx     = dual_reg ? CBSEL_LAST_DUAL : CBSEL_LAST_SINGLE;
  assign sample_ready = walk_reg == CBSEL_W_IDLE;

  // walk bits 0 to last_idx once per sample; a strobe while walking is not taken
  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      walk_reg <= CBSEL_W_IDLE;
      idx_reg  <= 5'h00;
    end else begin
      unique case (walk_reg)
        CBSEL_W_IDLE: begin
          idx_reg <= 5'h00;
          if (sample_strobe) begin
            walk_reg <= CBSEL_W_WALK;
          end
        end
        CBSEL_W_WALK: begin
          if (idx_reg == last_idx) begin
            walk_reg <= CBSEL_W_IDLE;
            idx_reg  <= 5'h00;
          end else begin
            idx_reg <= idx_reg + 5'h01;
          end
        end
      endcase
    end
  end

  // only set bits produce a stored word
  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      store_valid <= 1'b0;
      store_bit   <= 5'h00;
      store_data  <= 16'h0000;
    end else begin
      store_valid <= walk_reg == CBSEL_W_WALK && active_sel_reg[idx_reg];
      store_bit   <= idx_reg;
      store_data  <= slot_val;
    end
  end

  // ==========================================================
  // checks
  property p_freq_pair;
    @(posedge mclk) disable iff (!reset_n)
      select_reg[CBSEL_FLO_BIT] == select_reg[CBSEL_FHI_BIT];
  endproperty
  a_freq_pair: assert property (p_freq_pair) else $error("frequency halves not paired");

  property p_len_fits;
    @(posedge mclk) disable iff (!reset_n)
      (!buffer_mode_select && $stable(select_reg) && $stable(buffer_mode_select)) |-> length_reg <= max_length;
  endproperty
  a_len_fits: assert property (p_len_fits) else $error("length exceeds share");

  property p_fast_bounds;
    @(posedge mclk) disable iff (!reset_n)
      (len_wr && len_ok && buffer_mode_select) |=> length_reg >= CBSEL_FAST_MIN_LEN;
  endproperty
  a_fast_bounds: assert property (p_fast_bounds) else $error("fast length below minimum");

  property p_reject_keeps;
    @(posedge mclk) disable iff (!reset_n)
      (sel_wr && !sel_ok) |=> $stable(select_reg) && perr_reg;
  endproperty
  a_reject_keeps: assert property (p_reject_keeps) else $error("bad selection not rejected");

  property p_measured;
    @(posedge mclk) disable iff (!reset_n)
      (select_reg & CBSEL_MEASURED_MASK) != 22'h00_0000;
  endproperty
  a_measured: assert property (p_measured) else $error("selection lacks measured curve");

  property p_single_width;
    @(posedge mclk) disable iff (!reset_n)
      (sel_wr && sel_ok && !dual_reg) |=> select_reg[21:17] == 5'h00;
  endproperty
  a_single_width: assert property (p_single_width) else $error("single mode word too wide");

  property p_clear_cnt;
    @(posedge mclk) disable iff (!reset_n)
      cnt_clear |=> sweeps_reg == 32'h0000_0000 && points_reg == 32'h0000_0000;
  endproperty
  a_clear_cnt: assert property (p_clear_cnt) else $error("counters not cleared");

  property p_store_sel;
    @(posedge mclk) disable iff (!reset_n)
      store_valid |-> active_sel_reg[store_bit];
  endproperty
  a_store_sel: assert property (p_store_sel) else $error("unselected curve stored");

  property p_auto_cut;
    @(posedge mclk) disable iff (!reset_n)
      (sel_wr && sel_ok && !buffer_mode_select && length_reg > new_max) |=> length_reg == $past(new_max);
  endproperty
  a_auto_cut: assert property (p_auto_cut) else $error("length not reduced");

  c_sel_ok:   cover property (@(posedge mclk) disable iff (!reset_n) sel_wr && sel_ok);
  c_sel_bad:  cover property (@(posedge mclk) disable iff (!reset_n) sel_wr && !sel_ok);
  c_cut:      cover property (@(posedge mclk) disable iff (!reset_n) sel_wr && sel_ok && length_reg > new_max);
  c_store:    cover property (@(posedge mclk) disable iff (!reset_n) store_valid ##1 store_valid);

endmodule
`default_nettype wire

//--- tb/cbsel_meas_model.sv
`timescale 1ns/1ns
`default_nettype none
// ==========================================================
// measurement source
module cbsel_meas_model (
  input  wire logic        mclk,
  input  wire logic        hold,
  output logic      [15:0] x_in,
  output logic      [15:0] mag_in,
  output logic      [14:0] event_in,
  output logic      [31:0] ref_freq_in,
  output logic      [15:0] spare
);
  int v;
  // known values before the first edge
  initial begin
    x_in = 16'h0000;
    mag_in = 16'h0000;
    event_in = 15'h0000;
    ref_freq_in = 32'h0000_0000;
    spare = 16'h0000;
  end
  // fresh values every cycle; frozen while a walk reads them, else stored words would tear
  always @(posedge mclk) begin
    if (!hold) begin
      v = $urandom_range(20000);
      x_in <= 16'(v - 10000);
      mag_in <= 16'($urandom_range(10000));
      event_in <= 15'($urandom_range(32767));
      ref_freq_in <= $urandom;
      spare <= 16'($urandom);
    end
  end
endmodule
`default_nettype wire

//--- tb/curve_buffer_channel_select_bench.sv
`timescale 1ns/1ns
`default_nettype none
module curve_buffer_channel_select_bench;
  import cbsel_pkg::*;
  logic        mclk = 1'b0;
  logic        reset_n = 1'b0;
  logic        read = 1'b0;
  logic        write = 1'b0;
  logic        acq_start = 1'b0;
  logic        sample_strobe = 1'b0;
  logic        point_taken = 1'b0;
  logic        sweep_done = 1'b0;
  logic        hold = 1'b0;
  logic [4:0]  address = 5'h00;
  logic [4:0]  sens_in = 5'h05;
  logic [4:0]  dump_curve_num = 5'h00;
  logic [1:0]  input_mode_code = 2'h2;
  logic [31:0] writedata = 32'h0000_0000;
  logic [31:0] readdata, q, rf;
  logic        waitrequest, sample_ready, store_valid, dump_allowed, buffer_mode_select;
  logic [15:0] x_in, mag_in, spare, store_data;
  logic [4:0]  store_bit;
  logic [14:0] event_in;
  logic [21:0] curve_select_word;
  logic [16:0] curve_length;
  logic [20:0] exp_q[$];
  logic [31:0] bad[4] = '{32'h0000_0010, 32'h0002_0001, 32'h0040_0001, 32'h0000_0000};
  logic [7:0]  offs[4] = '{8'h00, 8'h20, 8'h40, 8'h80};
  int          mismatches = 0;
  int          samples_checked = 0;

  cbsel_top cbsel_top_i (
    .mclk, .reset_n, .address, .read, .write, .byteenable(4'hf), .writedata, .readdata,
    .waitrequest, .acq_start, .sample_strobe, .sample_ready, .point_taken, .sweep_done,
    .x_in, .y_in(spare), .mag_in, .phase_in(~spare), .sens_in, .input_mode_code,
    .noise_in(spare), .ratio_in(spare), .log_ratio_in(spare), .aux_in({4{spare}}),
    .user_out_in({2{spare}}), .event_in, .ref_freq_in(rf), .ch2_in({4{x_in}}),
    .sens2_in(5'h03), .input_mode_code2(2'h1), .store_valid, .store_bit, .store_data,
    .dump_curve_num, .dump_allowed, .buffer_mode_select, .curve_select_word, .curve_length);
  cbsel_meas_model cbsel_meas_model_i (.mclk, .hold, .x_in, .mag_in, .event_in, .ref_freq_in(rf), .spare);

  // ==========================================================
  // helpers
  initial begin
    forever #10 mclk = ~mclk;
  end
  task automatic tally_and_finish();
    $display("checked %0d mismatches %0d", samples_checked, mismatches);
    if (mismatches == 0 && samples_checked > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask
  task automatic check(input logic [31:0] seen, input logic [31:0] exp, input string what);
    samples_checked++;
    if (seen !== exp) begin
      mismatches++;
      $display("[FAIL] %s expected %h seen %h", what, exp, seen);
    end
  endtask
  // one avalon transfer; waitrequest and read data are taken at the rising edge, before its updates land
  task automatic bus(input logic w, input logic [4:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge mclk);
    address <= a;
    write <= w;
    read <= !w;
    writedata <= d;
    do begin
      @(posedge mclk);
      n++;
    end while (waitrequest !== 1'b0 && n < 50);
    if (waitrequest !== 1'b0) begin
      mismatches++;
      tally_and_finish();
    end
    q = readdata;
    read <= 1'b0;
    write <= 1'b0;
  endtask
  task automatic rd(input logic [4:0] a, input logic [31:0] e, input string what);
    bus(1'b0, a, 32'h0000_0000);
    check(q, e, what);
  endtask
  // stored words are taken off the note queue in arrival order
  always @(posedge mclk) begin
    if (store_valid === 1'b1) begin
      if (exp_q.size() == 0)
        check(32'h0000_0001, 32'h0000_0000, "unexpected store");
      else
        check({store_bit, store_data}, exp_q.pop_front(), "store word");
    end
  end
  initial begin
    #1_000_000;
    mismatches++;
    tally_and_finish();
  end

  // ==========================================================
  // main sequence
  initial begin
    void'($urandom(37));
    repeat (10) @(posedge mclk);
    reset_n <= 1'b1;
    rd(CBSEL_OFF_CTRL, 32'h0000_0000, "ctrl");
    rd(CBSEL_OFF_SELECT, 32'h0000_0001, "select");
    rd(CBSEL_OFF_LENGTH, 100000, "length");
    $display("test reset done");
    // low frequency half pulls in the high half; four curves share the store
    bus(1'b1, CBSEL_OFF_SELECT, 32'h0000_8011);
    rd(CBSEL_OFF_SELECT, 32'h0001_8011, "pair");
    check(curve_select_word, 32'h0001_8011, "select out");
    rd(CBSEL_OFF_LENGTH, 100000 / 4, "cut");
    rd(CBSEL_OFF_MAXLEN, 100000 / 4, "maxlen");
    bus(1'b1, CBSEL_OFF_STATUS, 32'h0000_0001);
    rd(CBSEL_OFF_STATUS, 32'h0000_0402, "status");
    foreach (bad[i]) begin
      bus(1'b1, CBSEL_OFF_STATUS, 32'h0000_0001);
      bus(1'b1, CBSEL_OFF_SELECT, bad[i]);
      rd(CBSEL_OFF_SELECT, 32'h0001_8011, "kept");
      rd(CBSEL_OFF_STATUS, 32'h0000_0403, "perr");
    end
    $display("test select done");
    // dual mode widens the word and the dumpable range
    bus(1'b1, CBSEL_OFF_CTRL, 32'h0000_0002);
    bus(1'b1, CBSEL_OFF_SELECT, 32'h0022_0001);
    rd(CBSEL_OFF_SELECT, 32'h0022_0001, "dual");
    foreach (offs[i]) begin
      dump_curve_num <= (i == 0) ? 5'd21 : (i == 1) ? 5'd17 : (i == 2) ? 5'd5 : 5'd22;
      repeat (2) @(posedge mclk);
      @(negedge mclk);
      check(dump_allowed, i < 2, "dump");
    end
    dump_curve_num <= 5'd0;
    bus(1'b1, CBSEL_OFF_SELECT, 32'h0001_8011);
    bus(1'b1, CBSEL_OFF_CTRL, 32'h0000_0000);
    $display("test dual done");
    // length limits in both buffer modes
    bus(1'b1, CBSEL_OFF_LENGTH, 25001);
    rd(CBSEL_OFF_LENGTH, 25000, "len kept");
    bus(1'b1, CBSEL_OFF_CTRL, 32'h0000_0001);
    @(negedge mclk);
    check(buffer_mode_select, 1'b1, "mode");
    bus(1'b1, CBSEL_OFF_LENGTH, 299);
    rd(CBSEL_OFF_LENGTH, 25000, "fast min");
    bus(1'b1, CBSEL_OFF_LENGTH, 300);
    @(negedge mclk);
    check(curve_length, 300, "fast 300");
    bus(1'b1, CBSEL_OFF_LENGTH, 100000);
    rd(CBSEL_OFF_LENGTH, 100000, "fast max");
    bus(1'b1, CBSEL_OFF_CTRL, 32'h0000_0000);
    rd(CBSEL_OFF_LENGTH, 25000, "back");
    $display("test length done");
    // each of the selection query, length query and new curve commands clears the sweep and point counts
    for (int i = 0; i < 3; i++) begin
      point_taken <= 1'b1;
      sweep_done <= 1'b1;
      repeat (3) @(posedge mclk);
      point_taken <= 1'b0;
      sweep_done <= 1'b0;
      rd(CBSEL_OFF_POINTS, 3, "points");
      rd(CBSEL_OFF_SWEEPS, 3, "sweeps");
      bus(1'b1, CBSEL_OFF_CMD, 32'h0000_0001 << i);
      rd(CBSEL_OFF_POINTS, 0, "points clr");
      rd(CBSEL_OFF_SWEEPS, 0, "sweeps clr");
    end
    $display("test counters done");
    // one walk per input mode with a random sensitivity
    acq_start <= 1'b1;
    @(posedge mclk);
    acq_start <= 1'b0;
    foreach (offs[i]) begin
      input_mode_code <= 2'(i);
      sens_in <= 5'($urandom_range(27, 1));
      hold <= 1'b1;
      repeat (2) @(posedge mclk);
      exp_q.push_back({5'd0, x_in});
      exp_q.push_back({5'd4, 8'h00, offs[i] + 8'(sens_in)});
      exp_q.push_back({5'd15, rf[15:0]});
      exp_q.push_back({5'd16, rf[31:16]});
      @(negedge mclk);
      check(sample_ready, 1'b1, "ready");
      @(posedge mclk);
      sample_strobe <= 1'b1;
      @(posedge mclk);
      sample_strobe <= 1'b0;
      repeat (40) @(posedge mclk);
      check(exp_q.size(), 0, "walk");
      hold <= 1'b0;
      @(posedge mclk);
    end
    $display("test stream done");
    tally_and_finish();
  end
endmodule
`default_nettype wire
